// ---- verilog/hbs_brake_seq.sv ----
// Holding brake sequencer: power stage, brake timing, manual release and trips

// Behaviour
// - Power stage enabled releases the brake
// - State 6 only after release time
// - Power stage disabled engages the brake
// - Keep current until apply time elapsed
// - Times come from motor nameplate data
// - Manual release only in states 3,4,9
// - Manual control bit, 0 auto, 1 release
// - Power stage enable clears manual bit
// - Manual bit write acts at once
// - Torque cutoff disables stage, error 1300
// - Tripped limit switch raises error
// - Limit switch enable and polarity configurable
module hbs_brake_seq #(
    parameter int                      N_LIMIT = 2,
    parameter int                      TW      = hbs_pkg::TIME_W
) (
    // Clock and reset
    input  wire logic                  sys_clk_i,
    input  wire logic                  sys_rst_i,
    // Parameter access
    input  wire logic                  param_wr_i,
    input  wire logic [15:0]           param_addr_i,
    input  wire logic [15:0]           param_wdata_i,
    output logic [15:0]                param_rdata_o,
    // Drive state machine
    input  wire logic                  stage_enable_req_i,
    input  wire logic [3:0]            op_state_i,
    // Motor nameplate times in microseconds
    input  wire logic [TW-1:0]         release_time_us_i,
    input  wire logic [TW-1:0]         apply_time_us_i,
    // Safety inputs
    input  wire logic                  torque_cutoff_input_a_i,
    input  wire logic                  torque_cutoff_input_b_i,
    input  wire logic [N_LIMIT-1:0]    limit_pin_i,
    input  wire logic [N_LIMIT-1:0]    limit_en_i,
    input  wire logic [N_LIMIT-1:0]    limit_nc_i,
    // Power stage and brake
    output logic                       motor_current_o,
    output logic                       brake_release_o,
    output logic                       op_enable_ok_o,
    // Errors
    output logic [15:0]                error_code_o,
    output logic                       limit_error_o
);
    localparam int CW = TW + 8;

    // Refuse sizes the cycle arithmetic and the switch vector cannot serve
    if (TW < 4 || TW > 24) begin : g_bad_tw
        $error("hbs_brake_seq: TW out of range");
    end
    if (N_LIMIT < 1) begin : g_bad_n
        $error("hbs_brake_seq: N_LIMIT below 1");
    end

    // Microseconds to clock cycles, least one cycle
    function automatic logic [CW-1:0] us_to_cyc(input logic [TW-1:0] us);
        logic [CW-1:0] c;
        c = CW'(us) * CW'(hbs_pkg::CYC_PER_US);
        if (c == '0) c = CW'(1);
        return c;
    endfunction

    // ****************************************
    // Limit switches
    // ****************************************
    logic [N_LIMIT-1:0] tripped;

    hbs_limit_in #(.N(N_LIMIT)) u_limit (
        .sys_clk_i   (sys_clk_i),
        .sys_rst_i   (sys_rst_i),
        .limit_pin_i (limit_pin_i),
        .limit_en_i  (limit_en_i),
        .limit_nc_i  (limit_nc_i),
        .tripped_o   (tripped)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    hbs_pkg::hbs_state_t st_q, st_d;
    logic                manual_q, manual_d;
    logic                cur_q, cur_d;
    logic                brk_q, brk_d;
    logic                opok_q, opok_d;
    logic [15:0]         err_q, err_d;
    logic                lim_q, lim_d;
    logic [15:0]         rdata_q, rdata_d;
    logic                tmr_load;
    logic [CW-1:0]       tmr_count;
    logic                tmr_done;
    logic                cutoff;
    logic                manual_ok;

    hbs_timer #(.W(CW)) u_timer (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .load_i    (tmr_load),
        .count_i   (tmr_count),
        .done_o    (tmr_done)
    );

    // Either channel low trips the cutoff; channels are kept apart in the wiring
    assign cutoff = !torque_cutoff_input_a_i || !torque_cutoff_input_b_i;

    // States where the brake may be opened by hand
    assign manual_ok = (op_state_i == hbs_pkg::OPST_SWITCH_ON_DIS) ||
                       (op_state_i == hbs_pkg::OPST_READY) ||
                       (op_state_i == hbs_pkg::OPST_FAULT);

    // Next state, timer loads and outputs
    always_comb begin
        st_d      = st_q;
        manual_d  = manual_q;
        err_d     = err_q;
        tmr_load  = 1'b0;
        tmr_count = '0;
        lim_d     = |tripped;
        // Manual bit write lands at once
        if (param_wr_i && param_addr_i == hbs_pkg::ADDR_BRAKE_MANUAL) begin
            manual_d = param_wdata_i[hbs_pkg::BRAKE_MANUAL_BIT];
        end
        case (st_q)
            hbs_pkg::HBS_OFF: begin
                if (stage_enable_req_i && !cutoff) begin
                    st_d      = hbs_pkg::HBS_RELEASING;
                    tmr_load  = 1'b1;
                    tmr_count = us_to_cyc(release_time_us_i);
                end
            end
            hbs_pkg::HBS_RELEASING: begin
                if (cutoff) begin
                    st_d = hbs_pkg::HBS_OFF;
                end else if (!stage_enable_req_i) begin
                    st_d      = hbs_pkg::HBS_APPLYING;
                    tmr_load  = 1'b1;
                    tmr_count = us_to_cyc(apply_time_us_i);
                end else if (tmr_done) begin
                    st_d = hbs_pkg::HBS_RUN;
                end
            end
            hbs_pkg::HBS_RUN: begin
                if (cutoff) begin
                    st_d = hbs_pkg::HBS_OFF;
                end else if (!stage_enable_req_i) begin
                    st_d      = hbs_pkg::HBS_APPLYING;
                    tmr_load  = 1'b1;
                    tmr_count = us_to_cyc(apply_time_us_i);
                end
            end
            hbs_pkg::HBS_APPLYING: begin
                if (cutoff || tmr_done) begin
                    st_d = hbs_pkg::HBS_OFF;
                end
            end
            default: begin
                st_d = hbs_pkg::HBS_OFF;
            end
        endcase
        // Enabling the stage returns brake handling to automatic
        if (st_d != hbs_pkg::HBS_OFF && st_d != hbs_pkg::HBS_APPLYING) begin
            manual_d = hbs_pkg::BRAKE_MODE_AUTO;
        end
        if (cutoff && st_q != hbs_pkg::HBS_OFF) begin
            err_d = hbs_pkg::ERR_TORQUE_CUTOFF;
        end else if (st_q == hbs_pkg::HBS_OFF && stage_enable_req_i && !cutoff) begin
            err_d = hbs_pkg::ERR_NONE;
        end
        // Current flows while enabled and during the apply wait
        cur_d  = (st_d != hbs_pkg::HBS_OFF);
        brk_d  = (st_d == hbs_pkg::HBS_RELEASING) || (st_d == hbs_pkg::HBS_RUN) ||
                 (st_d == hbs_pkg::HBS_OFF && manual_d && manual_ok);
        opok_d = (st_d == hbs_pkg::HBS_RUN);
        rdata_d = 16'h0000;
        if (param_addr_i == hbs_pkg::ADDR_BRAKE_MANUAL) begin
            rdata_d[hbs_pkg::BRAKE_MANUAL_BIT] = manual_d;
        end
    end

    // Registers
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q     <= hbs_pkg::HBS_OFF;
            manual_q <= hbs_pkg::BRAKE_MANUAL_RESET[hbs_pkg::BRAKE_MANUAL_BIT];
            cur_q    <= 1'b0;
            brk_q    <= 1'b0;
            opok_q   <= 1'b0;
            err_q    <= hbs_pkg::ERR_NONE;
            lim_q    <= 1'b0;
            rdata_q  <= 16'h0000;
        end else begin
            st_q     <= st_d;
            manual_q <= manual_d;
            cur_q    <= cur_d;
            brk_q    <= brk_d;
            opok_q   <= opok_d;
            err_q    <= err_d;
            lim_q    <= lim_d;
            rdata_q  <= rdata_d;
        end
    end

    assign motor_current_o = cur_q;
    assign brake_release_o = brk_q;
    assign op_enable_ok_o  = opok_q;
    assign error_code_o    = err_q;
    assign limit_error_o   = lim_q;
    assign param_rdata_o   = rdata_q;

    // ****************************************
    // Checks
    // ****************************************
    // Brake open without current only when opened by hand
    brake_needs_current_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (brake_release_o && !motor_current_o) |-> manual_q)
        else $error("Brake open without current outside manual mode");
    // Running means current on and brake open
    run_brake_open_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (st_q == hbs_pkg::HBS_RUN) |-> brake_release_o && motor_current_o)
        else $error("Brake closed or current off while running");
    // An accepted enable opens the brake and starts the release wait
    enable_opens_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (st_q == hbs_pkg::HBS_OFF && stage_enable_req_i && !cutoff) |=>
        st_q == hbs_pkg::HBS_RELEASING && motor_current_o && brake_release_o)
        else $error("Enable did not release the brake");
    // Operation allowed only straight out of a finished release wait
    op_after_release_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(op_enable_ok_o) |-> $past(st_q) == hbs_pkg::HBS_RELEASING && $past(tmr_done))
        else $error("Operation enabled before release time");
    // Operation flag only while running
    op_only_run_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        op_enable_ok_o |-> st_q == hbs_pkg::HBS_RUN)
        else $error("Operation flag outside run state");
    // No operation while the release count is still running
    release_wait_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (st_q == hbs_pkg::HBS_RELEASING && !tmr_done) |=> !op_enable_ok_o)
        else $error("Operation flag during release wait");
    // Counter at zero ends the release wait
    release_done_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (st_q == hbs_pkg::HBS_RELEASING && tmr_done && stage_enable_req_i && !cutoff) |=>
        st_q == hbs_pkg::HBS_RUN && op_enable_ok_o)
        else $error("Release wait did not end at zero count");
    // Brake held while applying
    brake_on_off_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (st_q == hbs_pkg::HBS_APPLYING) |-> !brake_release_o)
        else $error("Brake not engaged while applying");
    // Stage off and no manual request keeps the brake closed
    off_brake_closed_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (st_q == hbs_pkg::HBS_OFF && !manual_q) |-> !brake_release_o)
        else $error("Brake open with stage off in automatic mode");
    // Dropping the request closes the brake but keeps current
    disable_applies_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (st_q == hbs_pkg::HBS_RUN && !stage_enable_req_i && !cutoff) |=>
        st_q == hbs_pkg::HBS_APPLYING && motor_current_o && !brake_release_o)
        else $error("Disable did not start the apply wait");
    // Current must outlast the apply wait
    current_during_apply_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (st_q == hbs_pkg::HBS_APPLYING && !tmr_done && !cutoff) |=> motor_current_o)
        else $error("Current removed before apply time");
    // Counter at zero ends the apply wait and removes current
    apply_ends_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (st_q == hbs_pkg::HBS_APPLYING && tmr_done) |=> st_q == hbs_pkg::HBS_OFF && !motor_current_o)
        else $error("Apply wait did not end at zero count");
    // Hand release refused outside the permitted states
    manual_gate_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (manual_d && st_d == hbs_pkg::HBS_OFF && !manual_ok) |=> !brake_release_o)
        else $error("Manual release outside allowed states");
    // Hand release granted in a permitted state with the stage off
    manual_open_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (param_wr_i && param_addr_i == hbs_pkg::ADDR_BRAKE_MANUAL && param_wdata_i[hbs_pkg::BRAKE_MANUAL_BIT]
         && st_q == hbs_pkg::HBS_OFF && !stage_enable_req_i && manual_ok) |=> brake_release_o)
        else $error("Manual release not granted");
    // Read back shows the stored bit and nothing else
    manual_read_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (param_addr_i == hbs_pkg::ADDR_BRAKE_MANUAL) |=>
        param_rdata_o == (16'(manual_q) << hbs_pkg::BRAKE_MANUAL_BIT))
        else $error("Manual bit read back wrong");
    // Other addresses read zero
    other_read_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (param_addr_i != hbs_pkg::ADDR_BRAKE_MANUAL) |=> param_rdata_o == 16'h0000)
        else $error("Unmapped address read nonzero");
    // No manual request survives while running
    manual_cleared_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (st_q == hbs_pkg::HBS_RUN) |-> !manual_q)
        else $error("Manual bit set while stage enabled");
    // An accepted enable returns brake handling to automatic
    enable_clears_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (st_q == hbs_pkg::HBS_OFF && stage_enable_req_i && !cutoff) |=> !manual_q)
        else $error("Enable did not clear the manual bit");
    // A write with the stage off lands on the next edge
    manual_write_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (param_wr_i && param_addr_i == hbs_pkg::ADDR_BRAKE_MANUAL && st_q == hbs_pkg::HBS_OFF
         && !(stage_enable_req_i && !cutoff)) |=> manual_q == $past(param_wdata_i[hbs_pkg::BRAKE_MANUAL_BIT]))
        else $error("Manual bit write not taken at once");
    // Cutoff while running stops the stage and reports
    cutoff_error_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (cutoff && st_q == hbs_pkg::HBS_RUN) |=> !motor_current_o && error_code_o == hbs_pkg::ERR_TORQUE_CUTOFF)
        else $error("Torque cutoff did not stop stage");
    // Cutoff during the release wait stops the stage and reports
    cutoff_release_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (cutoff && st_q == hbs_pkg::HBS_RELEASING) |=>
        !motor_current_o && error_code_o == hbs_pkg::ERR_TORQUE_CUTOFF)
        else $error("Torque cutoff ignored during release");
    // Enable refused while the cutoff is active
    cutoff_refuse_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (cutoff && st_q == hbs_pkg::HBS_OFF) |=> st_q == hbs_pkg::HBS_OFF && !motor_current_o)
        else $error("Stage enabled during torque cutoff");
    // Only the two known error codes appear
    error_values_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        error_code_o == hbs_pkg::ERR_NONE || error_code_o == hbs_pkg::ERR_TORQUE_CUTOFF)
        else $error("Unknown error code shown");
    // The error stands until the next accepted enable
    error_hold_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (st_q == hbs_pkg::HBS_OFF && !(stage_enable_req_i && !cutoff)) |=> $stable(error_code_o))
        else $error("Error code changed with stage off");
    // An enabled tripped switch reports two edges later
    limit_flag_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (|(limit_en_i & (limit_pin_i ^ limit_nc_i))) |-> ##2 limit_error_o)
        else $error("Limit trip not reported");
    // Disabled or resting switches never report
    limit_clear_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        !(|(limit_en_i & (limit_pin_i ^ limit_nc_i))) |-> ##2 !limit_error_o)
        else $error("Limit error without an enabled trip");

endmodule // hbs_brake_seq

// ---- verilog/hbs_pkg.sv ----
// Package of constants and types for the holding brake sequencer
package hbs_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [15:0] ADDR_BRAKE_MANUAL   = 16'h0814;
    localparam logic [15:0] BRAKE_MANUAL_RESET  = 16'h0000;
    localparam int          BRAKE_MANUAL_BIT    = 0;
    localparam logic        BRAKE_MODE_AUTO     = 1'b0;
    localparam logic        BRAKE_MODE_MANUAL   = 1'b1;

    // ****************************************
    // Operating states and error codes
    // ****************************************
    localparam logic [3:0]  OPST_SWITCH_ON_DIS  = 4'h3;
    localparam logic [3:0]  OPST_READY          = 4'h4;
    localparam logic [3:0]  OPST_OP_ENABLED     = 4'h6;
    localparam logic [3:0]  OPST_FAULT          = 4'h9;
    localparam logic [15:0] ERR_TORQUE_CUTOFF   = 16'h1300;
    localparam logic [15:0] ERR_NONE            = 16'h0000;

    // ****************************************
    // Timing
    // ****************************************
    localparam int          CLK_PERIOD_NS       = 10;
    localparam int          TIME_UNIT_US        = 1;
    localparam int          CYC_PER_US          = (TIME_UNIT_US * 1000) / CLK_PERIOD_NS;
    localparam int          TIME_W              = 16;

    // Power stage and brake sequence
    typedef enum logic [2:0] {
        HBS_OFF,
        HBS_RELEASING,
        HBS_RUN,
        HBS_APPLYING
    } hbs_state_t;

endpackage : hbs_pkg

// ---- verilog/hbs_timer.sv ----
// Down-counter that times one brake transition
module hbs_timer #(
    parameter int W = 32
) (
    // Clock and reset
    input  wire logic         sys_clk_i,
    input  wire logic         sys_rst_i,
    // Control
    input  wire logic         load_i,
    input  wire logic [W-1:0] count_i,
    // Status
    output logic              done_o
);
    if (W < 2) begin : g_bad_w
        $error("hbs_timer: width too small");
    end

    logic [W-1:0] cnt_q, cnt_d;

    // Load on request, else count down to zero
    always_comb begin
        cnt_d = cnt_q;
        if (load_i) begin
            cnt_d = count_i;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - W'(1);
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign done_o = (cnt_q == '0) && !load_i;

endmodule // hbs_timer

// ---- verilog/hbs_limit_in.sv ----
// Limit switch conditioning: enable and contact polarity
module hbs_limit_in #(
    parameter int N = 2
) (
    // Clock and reset
    input  wire logic         sys_clk_i,
    input  wire logic         sys_rst_i,
    // Switch pins and configuration
    input  wire logic [N-1:0] limit_pin_i,
    input  wire logic [N-1:0] limit_en_i,
    input  wire logic [N-1:0] limit_nc_i,
    // Tripped flags
    output logic [N-1:0]      tripped_o
);
    if (N < 1) begin : g_bad_n
        $error("hbs_limit_in: need one switch");
    end

    logic [N-1:0] trip_q, trip_d;

    // Normally-closed contacts trip on an open (low) pin
    always_comb begin
        trip_d = limit_en_i & (limit_pin_i ^ limit_nc_i);
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            trip_q <= '0;
        end else begin
            trip_q <= trip_d;
        end
    end

    assign tripped_o = trip_q;

endmodule // hbs_limit_in

// ---- verification/hbs_far_model.sv ----
// Far side model: limit switch contacts and the two torque cutoff channels
module hbs_far_model #(
    parameter int N = 2
) (
    // Stimulus from the bench
    input  wire logic         cut_a_i,
    input  wire logic         cut_b_i,
    input  wire logic [N-1:0] pressed_i,
    input  wire logic [N-1:0] nc_i,
    // Pins into the sequencer
    output logic              cutoff_a_n_o,
    output logic              cutoff_b_n_o,
    output logic [N-1:0]      limit_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Contacts
    // ****************************************
    // Cutoff channels idle high; a tripped channel pulls its line low
    assign cutoff_a_n_o = ~cut_a_i;
    assign cutoff_b_n_o = ~cut_b_i;
    // A normally closed contact reads 1 at rest and opens when pressed
    assign limit_pin_o  = pressed_i ^ nc_i;
endmodule // hbs_far_model

// ---- verification/tb_hbs_brake_seq.sv ----
// Self-checking testbench for the holding brake sequencer
module tb_hbs_brake_seq;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk_i, sys_rst_i, param_wr_i, stage_enable_req_i, cut_a, cut_b;
    logic [15:0] param_addr_i, param_wdata_i, param_rdata_o, error_code_o;
    logic [3:0]  op_state_i;
    logic [15:0] rel_us, app_us;
    logic [1:0]  pressed, limit_en, limit_nc, limit_pin;
    logic        cut_a_n, cut_b_n, motor_current_o, brake_release_o, op_enable_ok_o, limit_error_o;
    logic [2:0]  watch;
    int          err_count, cmp_count, n;
    logic [3:0]  states [5] = '{4'h3, 4'h4, 4'h9, 4'h6, 4'h0};
    logic        opens [5]  = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

    assign watch = {limit_error_o, motor_current_o, op_enable_ok_o};

    hbs_brake_seq u_hbs_brake_seq (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .param_wr_i(param_wr_i),
        .param_addr_i(param_addr_i), .param_wdata_i(param_wdata_i), .param_rdata_o(param_rdata_o),
        .stage_enable_req_i(stage_enable_req_i), .op_state_i(op_state_i), .release_time_us_i(rel_us),
        .apply_time_us_i(app_us), .torque_cutoff_input_a_i(cut_a_n), .torque_cutoff_input_b_i(cut_b_n),
        .limit_pin_i(limit_pin), .limit_en_i(limit_en), .limit_nc_i(limit_nc),
        .motor_current_o(motor_current_o), .brake_release_o(brake_release_o), .op_enable_ok_o(op_enable_ok_o),
        .error_code_o(error_code_o), .limit_error_o(limit_error_o));

    hbs_far_model u_hbs_far_model (.cut_a_i(cut_a), .cut_b_i(cut_b), .pressed_i(pressed), .nc_i(limit_nc),
        .cutoff_a_n_o(cut_a_n), .cutoff_b_n_o(cut_b_n), .limit_pin_o(limit_pin));

    // ****************************************
    // Clock and shared tasks
    // ****************************************
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic wrap_up();
        $display("errors=%0d compares=%0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Let k edges pass, then step off the edge so registered outputs have settled
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        param_wr_i    <= 1'b1;
        param_addr_i  <= a;
        param_wdata_i <= d;
        @(posedge sys_clk_i);
        param_wr_i    <= 1'b0;
    endtask

    // Read data answers the address of the previous cycle
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge sys_clk_i);
        param_addr_i <= a;
        cyc(2);
        check(param_rdata_o, exp);
    endtask

    // Bounded wait for one watched output to reach a level
    task automatic wait_lvl(input int idx, input logic v, output int k);
        k = 0;
        while (watch[idx] !== v) begin
            cyc(1);
            k++;
            if (k > 1000) begin
                err_count++;
                wrap_up();
            end
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        {param_wr_i, stage_enable_req_i, cut_a, cut_b} = 4'h0;
        {param_addr_i, param_wdata_i} = 32'h0;
        {op_state_i, pressed, limit_en, limit_nc} = 10'h0;
        {rel_us, app_us} = {16'h0002, 16'h0001};
        err_count = 0;
        cmp_count = 0;
        sys_rst_i = 1'b1;
        repeat (6) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        cyc(1);
        check({12'h0, watch, brake_release_o}, 16'h0000);
        check(error_code_o, hbs_pkg::ERR_NONE);
        rd(hbs_pkg::ADDR_BRAKE_MANUAL, hbs_pkg::BRAKE_MANUAL_RESET);
        // Manual release across allowed and refused states
        foreach (states[i]) begin
            op_state_i <= states[i];
            wr(hbs_pkg::ADDR_BRAKE_MANUAL, 16'h0001);
            cyc(2);
            check({15'h0, brake_release_o}, {15'h0, opens[i]});
            wr(hbs_pkg::ADDR_BRAKE_MANUAL, 16'h0000);
            cyc(2);
            check({15'h0, brake_release_o}, 16'h0000);
        end
        // Unmapped address stores nothing and reads zero
        wr(16'h0816, 16'h0001);
        rd(16'h0816, 16'h0000);
        // Enable and disable with two nameplate time sets
        for (int i = 0; i < 2; i++) begin
            op_state_i <= hbs_pkg::OPST_SWITCH_ON_DIS;
            wr(hbs_pkg::ADDR_BRAKE_MANUAL, 16'h0001);
            rel_us <= 16'(2 + i);
            app_us <= 16'(1 + 2 * i);
            stage_enable_req_i <= 1'b1;
            cyc(2);
            check({14'h0, motor_current_o, brake_release_o}, 16'h0003);
            rd(hbs_pkg::ADDR_BRAKE_MANUAL, 16'h0000);
            wait_lvl(0, 1'b1, n);
            check(16'(n > (2 + i) * 90 && n < (2 + i) * 100 + 10), 16'h0001);
            // A hand release written while running is dropped
            wr(hbs_pkg::ADDR_BRAKE_MANUAL, 16'h0001);
            rd(hbs_pkg::ADDR_BRAKE_MANUAL, 16'h0000);
            stage_enable_req_i <= 1'b0;
            cyc(2);
            check({13'h0, watch[1:0], brake_release_o}, 16'h0004);
            wait_lvl(1, 1'b0, n);
            check(16'(n > (1 + 2 * i) * 90 && n < (1 + 2 * i) * 100 + 10), 16'h0001);
        end
        // Torque cutoff on each channel; the bench re-enables only by hand
        for (int i = 0; i < 2; i++) begin
            stage_enable_req_i <= 1'b1;
            wait_lvl(0, 1'b1, n);
            if (i == 0) cut_a <= 1'b1;
            else cut_b <= 1'b1;
            cyc(2);
            check({14'h0, motor_current_o, brake_release_o}, 16'h0000);
            check(error_code_o, hbs_pkg::ERR_TORQUE_CUTOFF);
            // Request still held while the cutoff stands: the stage stays off
            cyc(3);
            check({14'h0, motor_current_o, brake_release_o}, 16'h0000);
            stage_enable_req_i <= 1'b0;
            {cut_a, cut_b} <= 2'b00;
            cyc(3);
            stage_enable_req_i <= 1'b1;
            cyc(3);
            check(error_code_o, hbs_pkg::ERR_NONE);
            stage_enable_req_i <= 1'b0;
            wait_lvl(1, 1'b0, n);
        end
        // Reset in mid-run: once while releasing, once with the brake opened by hand
        for (int i = 0; i < 2; i++) begin
            op_state_i <= hbs_pkg::OPST_SWITCH_ON_DIS;
            stage_enable_req_i <= (i == 0);
            if (i == 1) wr(hbs_pkg::ADDR_BRAKE_MANUAL, 16'h0001);
            cyc(3);
            check({15'h0, brake_release_o}, 16'h0001);
            sys_rst_i <= 1'b1;
            cyc(2);
            check({12'h0, watch, brake_release_o}, 16'h0000);
            stage_enable_req_i <= 1'b0;
            sys_rst_i <= 1'b0;
            cyc(2);
            check({12'h0, watch, brake_release_o}, 16'h0000);
            rd(hbs_pkg::ADDR_BRAKE_MANUAL, hbs_pkg::BRAKE_MANUAL_RESET);
        end
        // Limit switches: one open contact, one closed contact
        limit_en <= 2'b11;
        limit_nc <= 2'b10;
        cyc(4);
        check({15'h0, limit_error_o}, 16'h0000);
        for (int i = 0; i < 2; i++) begin
            pressed <= 2'(1 << i);
            cyc(4);
            check({15'h0, limit_error_o}, 16'h0001);
            limit_en <= ~2'(1 << i);
            cyc(4);
            check({15'h0, limit_error_o}, 16'h0000);
            limit_en <= 2'b11;
            pressed <= 2'b00;
            cyc(4);
        end
        wrap_up();
    end
endmodule // tb_hbs_brake_seq
